// [design/ubt_burst.sv]
// Device end of a parallel burst port: data-in termination, checksum
// hand-off and data-out initiation up to the first host strobe.
// Assumes pin inputs are asynchronous; link_clock is free running.
//
// Function
// - Device ends data-in by halting strobes, drops request tSS after last edge.
// - Device releases the data bus within tAZ of dropping its request.
// - Device raises a low strobe within tLI of STOP, holds it high.
// - Device captures host checksum on the releasing edge of acknowledge.
// - Device compares checksums, keeps first miscompare, reports it at command end.
// - Device releases its strobe line two synchroniser cycles after acknowledge release, above the one-cycle tIORDYZ.
// - Device halts strobes within tRFS when host negates its ready.
// - Device drops request within tLI of STOP, not reasserting before end.
// - Device may drive its ready negated tZIORDY after acknowledge, till release.
// - Device asserts ready within tLI of STOP low, holds both until first strobe.
// - A burst spans acknowledge assertion to release; burst state runs from the start pulse to a release seen past the request states.
// - Both ends run a sixteen-bit checksum over every data-in burst.
`timescale 1ns/100ps
`default_nettype none
module ubt_burst
   import ubt_pkg::*;
(
   input  wire logic        clock,        // Core clock, 50 MHz.
   input  wire logic        reset,        // Asynchronous, active high.
   input  wire logic        link_clock,   // Free-running link sampling clock.
   input  wire logic [1:0]  mode,         // Selected transfer mode 0..2.
   input  wire logic        cmd_start,    // Pulse: a command begins.
   input  wire logic        cmd_done,     // Pulse: the command completes.
   input  wire logic        in_start,     // Pulse: request a data-in burst.
   input  wire logic        in_valid,     // A data-in word is offered.
   input  wire logic [15:0] in_data,      // Data-in word, held until taken.
   input  wire logic        in_end,       // Level: end the data-in burst.
   input  wire logic        out_start,    // Pulse: request a data-out burst.
   input  wire logic        dmack_n_i,    // Host acknowledge pin, low active.
   input  wire logic        stop_i,       // Host stop pin.
   input  wire logic        hrdy_strb_i,  // Host ready (low) or host strobe.
   input  wire logic [15:0] dd_i,         // Data bus, input side.
   output logic [15:0]      dd_o,         // Data bus, output side.
   output logic             dd_oe,        // Data bus output enable.
   output logic             dmarq,        // Burst request to host.
   output logic             drdy_strb_o,  // Device strobe or ready (low).
   output logic             drdy_strb_oe, // Enable for that line.
   output logic             in_ready,     // Pulse: data-in word strobed out.
   output logic             out_first,    // Pulse: first host strobe seen.
   output logic             busy,         // A burst is in progress.
   output logic             crc_error     // Checksum error of last command.
);

   ubt_state_t  state_reg;
   logic [7:0]  cnt_reg;
   logic        loaded_reg;
   logic [15:0] dd_reg;
   logic        dd_oe_reg, dmarq_reg, strb_reg, strb_oe_reg;
   logic        in_ready_reg, out_first_reg, busy_reg, crc_error_reg;
   logic        err_seen_reg;
   logic [2:0]  ack_sync_reg, stop_sync_reg, hrs_sync_reg;
   logic        ack_on, stop_s, hrs_s, ack_rise, ack_fall, hrs_fall;
   logic [1:0]  ldma_sync_reg, lack_hist_reg;
   logic [15:0] ldd_s1_reg, ldd_s2_reg, lcrc_reg;
   logic        ltgl_reg;
   logic [2:0]  ctgl_sync_reg;
   logic        crc_new;
   logic [7:0]  since_edge_reg;

   ubt_crc_if crc_bus ();

   ubt_crc u_crc (
      .clock (clock),
      .reset (reset),
      .port  (crc_bus.calc)
   );

   // Mode lookup of the data setup and cycle figures.
   function automatic logic [7:0] mode_dvs(input logic [1:0] m);
      case (m)
         2'h0:    return CNT_DVS0;
         2'h1:    return CNT_DVS1;
         default: return CNT_DVS2;
      endcase
   endfunction

   function automatic logic [7:0] mode_cyc(input logic [1:0] m);
      case (m)
         2'h0:    return CNT_CYC0;
         2'h1:    return CNT_CYC1;
         default: return CNT_CYC2;
      endcase
   endfunction

   // Pin synchronisers; the third stage only feeds edge detection.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ack_sync_reg  <= 3'h7;
         stop_sync_reg <= 3'h0;
         hrs_sync_reg  <= 3'h7;
      end else begin
         ack_sync_reg  <= {ack_sync_reg[1:0], dmack_n_i};
         stop_sync_reg <= {stop_sync_reg[1:0], stop_i};
         hrs_sync_reg  <= {hrs_sync_reg[1:0], hrdy_strb_i};
      end
   end

   assign ack_on   = !ack_sync_reg[1];
   assign stop_s   = stop_sync_reg[1];
   assign hrs_s    = hrs_sync_reg[1];
   // Edges are named after the pin: a rise is the acknowledge release.
   assign ack_rise = !ack_sync_reg[2] && ack_sync_reg[1];
   assign ack_fall = ack_sync_reg[2] && !ack_sync_reg[1];
   assign hrs_fall = hrs_sync_reg[2] && !hrs_sync_reg[1];

   // Link side: sample the bus and catch the host checksum when the
   // acknowledge releases. The word is held stable until the next burst,
   // so a toggle is enough to tell the core a new one is there.
   always_ff @(posedge link_clock or posedge reset) begin
      if (reset) begin
         ldma_sync_reg <= 2'h3;
         lack_hist_reg <= 2'h3;
         ldd_s1_reg    <= DD_RESET;
         ldd_s2_reg    <= DD_RESET;
         lcrc_reg      <= DD_RESET;
         ltgl_reg      <= 1'b0;
      end else begin
         ldma_sync_reg <= {ldma_sync_reg[0], dmack_n_i};
         lack_hist_reg <= {lack_hist_reg[0], ldma_sync_reg[1]};
         ldd_s1_reg    <= dd_i;
         ldd_s2_reg    <= ldd_s1_reg;
         if (!lack_hist_reg[0] && ldma_sync_reg[1]) begin
            lcrc_reg <= ldd_s2_reg;
            ltgl_reg <= !ltgl_reg;
         end
      end
   end

   // Toggle crossing of the capture event into the core domain.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctgl_sync_reg <= 3'h0;
      end else begin
         ctgl_sync_reg <= {ctgl_sync_reg[1:0], ltgl_reg};
      end
   end

   assign crc_new = ctgl_sync_reg[2] ^ ctgl_sync_reg[1];

   // First miscompare of a command is kept; a new error wins over the clear.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         err_seen_reg  <= 1'b0;
         crc_error_reg <= 1'b0;
      end else begin
         if (crc_new && lcrc_reg != crc_bus.crc) begin
            err_seen_reg <= 1'b1;
         end else if (cmd_start) begin
            err_seen_reg <= 1'b0;
         end
         if (cmd_done) begin
            crc_error_reg <= err_seen_reg;
         end
      end
   end

   // Checksum restarts at acknowledge assertion and folds each sent word.
   assign crc_bus.clear  = ack_fall;
   assign crc_bus.enable = state_reg == ST_IN_XFER && loaded_reg &&
                           cnt_reg == CNT_RESET && !hrs_s && !stop_s;
   assign crc_bus.data   = dd_reg;

   // Burst sequencer. Pin latency through the synchronisers is two cycles,
   // inside tLI and tRFS but above the one-cycle tIORDYZ, which no timer covers.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg     <= ST_IDLE;
         cnt_reg       <= CNT_RESET;
         loaded_reg    <= 1'b0;
         dd_reg        <= DD_RESET;
         dd_oe_reg     <= 1'b0;
         dmarq_reg     <= 1'b0;
         strb_reg      <= 1'b1;
         strb_oe_reg   <= 1'b0;
         in_ready_reg  <= 1'b0;
         out_first_reg <= 1'b0;
         busy_reg      <= 1'b0;
      end else begin
         in_ready_reg  <= 1'b0;
         out_first_reg <= 1'b0;
         if (cnt_reg != CNT_RESET) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
         case (state_reg)
            ST_IDLE: begin
               busy_reg <= in_start || out_start;
               if (in_start) begin
                  dmarq_reg <= 1'b1;
                  state_reg <= ST_IN_REQ;
               end else if (out_start) begin
                  dmarq_reg <= 1'b1;
                  state_reg <= ST_OUT_REQ;
               end
            end
            ST_IN_REQ: begin
               if (ack_on && !stop_s && !hrs_s) begin
                  strb_oe_reg <= 1'b1;
                  dd_oe_reg   <= 1'b1;
                  loaded_reg  <= 1'b0;
                  state_reg   <= ST_IN_XFER;
               end
            end
            ST_IN_XFER: begin
               if (stop_s) begin
                  dmarq_reg  <= 1'b0;
                  dd_oe_reg  <= 1'b0;
                  strb_reg   <= 1'b1;
                  state_reg  <= ST_IN_TERM;
               end else if (hrs_s) begin
                  // Host pause or host end: no edges until ready returns.
                  state_reg <= ST_IN_XFER;
               end else if (!loaded_reg && in_end) begin
                  cnt_reg   <= CNT_SS;
                  state_reg <= ST_IN_SS;
               end else if (!loaded_reg && in_valid &&
                            cnt_reg == CNT_RESET) begin
                  dd_reg     <= in_data;
                  loaded_reg <= 1'b1;
                  cnt_reg    <= mode_dvs(mode);
               end else if (loaded_reg && cnt_reg == CNT_RESET) begin
                  strb_reg     <= !strb_reg;
                  in_ready_reg <= 1'b1;
                  loaded_reg   <= 1'b0;
                  cnt_reg      <= mode_cyc(mode);
               end
            end
            ST_IN_SS: begin
               if (cnt_reg == CNT_RESET) begin
                  dmarq_reg <= 1'b0;
                  dd_oe_reg <= 1'b0;
                  state_reg <= ST_IN_STOPWAIT;
               end
            end
            ST_IN_STOPWAIT: begin
               if (stop_s) begin
                  strb_reg  <= 1'b1;
                  state_reg <= ST_IN_TERM;
               end
            end
            ST_IN_TERM: begin
               strb_reg <= 1'b1;
            end
            ST_OUT_REQ: begin
               if (ack_on) begin
                  cnt_reg   <= CNT_ZIORDY;
                  state_reg <= ST_OUT_ZIO;
               end
            end
            ST_OUT_ZIO: begin
               if (cnt_reg == CNT_RESET) begin
                  strb_oe_reg <= 1'b1;
                  strb_reg    <= 1'b1;
                  state_reg   <= ST_OUT_STOPWAIT;
               end
            end
            ST_OUT_STOPWAIT: begin
               if (!stop_s) begin
                  strb_reg  <= 1'b0;
                  state_reg <= ST_OUT_READY;
               end
            end
            ST_OUT_READY: begin
               if (hrs_fall) begin
                  out_first_reg <= 1'b1;
                  state_reg     <= ST_OUT_XFER;
               end
            end
            ST_OUT_XFER: begin
               state_reg <= ST_OUT_XFER;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         // The acknowledge release ends a burst outside the idle and request states and frees the lines.
         if (ack_rise && state_reg != ST_IDLE && state_reg != ST_IN_REQ &&
             state_reg != ST_OUT_REQ) begin
            strb_oe_reg <= 1'b0;
            strb_reg    <= 1'b1;
            dd_oe_reg   <= 1'b0;
            dmarq_reg   <= 1'b0;
            loaded_reg  <= 1'b0;
            busy_reg    <= 1'b0;
            state_reg   <= ST_IDLE;
         end
      end
   end

   assign dd_o         = dd_reg;
   assign dd_oe        = dd_oe_reg;
   assign dmarq        = dmarq_reg;
   assign drdy_strb_o  = strb_reg;
   assign drdy_strb_oe = strb_oe_reg;
   assign in_ready     = in_ready_reg;
   assign out_first    = out_first_reg;
   assign busy         = busy_reg;
   assign crc_error    = crc_error_reg;

   // Cycles since the last strobe edge, saturating; checking aid only.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         since_edge_reg <= 8'hFF;
      end else if (in_ready_reg) begin
         since_edge_reg <= 8'h01;
      end else if (since_edge_reg != 8'hFF) begin
         since_edge_reg <= since_edge_reg + 8'h01;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_ss_before_drop: assert property (
      $past(state_reg) == ST_IN_SS && $fell(dmarq_reg)
      |-> since_edge_reg > CNT_SS)
      else $error("request dropped too soon after last strobe edge");

   a_bus_released: assert property (
      state_reg == ST_IN_STOPWAIT |-> !dd_oe_reg && !dmarq_reg)
      else $error("data bus still driven after request drop");

   a_strobe_high: assert property (
      state_reg == ST_IN_STOPWAIT && stop_s && !ack_rise
      |=> strb_reg ##1 strb_reg)
      else $error("strobe not raised after host stop");

   a_strobe_release: assert property (
      ack_rise && state_reg != ST_IDLE |=> !strb_oe_reg)
      else $error("strobe line not released after acknowledge");

   a_pause_no_edge: assert property (
      state_reg == ST_IN_XFER && hrs_s && !stop_s && !ack_rise
      |=> $stable(strb_reg))
      else $error("strobe edge while host not ready");

   a_stop_drops_req: assert property (
      state_reg == ST_IN_XFER && stop_s && !ack_rise
      |=> !dmarq_reg [*2])
      else $error("request not dropped after host stop");

   a_ready_hold: assert property (
      strb_oe_reg && state_reg == ST_OUT_READY && !ack_rise
      |=> strb_oe_reg)
      else $error("device ready line released early");

   a_ready_assert: assert property (
      state_reg == ST_OUT_STOPWAIT && !stop_s && !ack_rise
      |=> !strb_reg && dmarq_reg)
      else $error("device ready not asserted after stop low");

   a_first_err_kept: assert property (
      err_seen_reg && !cmd_start |=> err_seen_reg)
      else $error("recorded checksum error lost");

   a_err_report: assert property (
      cmd_done |=> crc_error_reg == $past(err_seen_reg))
      else $error("command end did not report recorded error");

   c_dev_term:  cover property (state_reg == ST_IN_SS ##[1:20] state_reg == ST_IN_TERM);
   c_host_term: cover property (state_reg == ST_IN_XFER && stop_s);
   c_out_first: cover property (out_first_reg);
   c_crc_err:   cover property (crc_new && lcrc_reg != crc_bus.crc);

endmodule
`default_nettype wire

// [design/ubt_crc.sv]
// Sixteen-bit checksum calculator folded over the words of one burst.
// Assumes clear and enable come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ubt_crc
   import ubt_pkg::*;
(
   input wire logic  clock,  // Core clock.
   input wire logic  reset,  // Asynchronous, active high.
   ubt_crc_if.calc   port    // Control and result.
);

   logic [15:0] crc_reg;
   logic [15:0] crc_next;

   // Serial polynomial division unrolled over the sixteen data bits.
   function automatic logic [15:0] fold(input logic [15:0] c,
                                        input logic [15:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         if (r[15] ^ d[i]) begin
            r = {r[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction

   assign crc_next = fold(crc_reg, port.data);

   // Clear wins over a word in the same cycle: a new burst never inherits.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         crc_reg <= CRC_SEED;
      end else if (port.clear) begin
         crc_reg <= CRC_SEED;
      end else if (port.enable) begin
         crc_reg <= crc_next;
      end
   end

   assign port.crc = crc_reg;

   a_crc_clear_seed: assert property (@(posedge clock) disable iff (reset)
      port.clear |=> crc_reg == CRC_SEED)
      else $error("checksum not at seed after clear");

endmodule
`default_nettype wire

// [design/ubt_crc_if.sv]
// Connection between the burst engine and its checksum calculator.
// Assumes both ends run on the core clock.
`timescale 1ns/100ps
`default_nettype none
interface ubt_crc_if;
   logic        clear;   // Restart at the seed.
   logic        enable;  // Fold in one word.
   logic [15:0] data;    // Word to fold in.
   logic [15:0] crc;     // Running checksum.
   modport core (output clear, output enable, output data, input crc);
   modport calc (input clear, input enable, input data, output crc);
endinterface
`default_nettype wire

// [design/ubt_pkg.sv]
// Shared constants, timing figures and state encoding for the burst port.
// Assumes a 50 MHz core clock; every figure in ns is turned into cycles here.
package ubt_pkg;

   localparam int CLK_NS = 20;

   // Least times round up, longest times round down, never below one cycle.
   function automatic int cyc_min(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int cyc_max(input int ns);
      int c;
      c = ns / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Interval figures in ns (plain defaults, same for every mode).
   localparam int T_SS_NS     = 50;
   localparam int T_AZ_NS     = 10;
   localparam int T_LI_NS     = 150;
   localparam int T_MLI_NS    = 20;
   localparam int T_RFS_NS    = 75;
   localparam int T_RP_NS     = 160;
   localparam int T_ACK_NS    = 20;
   localparam int T_ENV_NS    = 70;
   localparam int T_IORDYZ_NS = 20;
   localparam int T_ZIORDY_NS = 0;

   // Mode-dependent figures in ns, for transfer modes 0, 1 and 2.
   localparam int T_DVS0_NS = 70;
   localparam int T_DVS1_NS = 48;
   localparam int T_DVS2_NS = 34;
   localparam int T_CYC0_NS = 112;
   localparam int T_CYC1_NS = 73;
   localparam int T_CYC2_NS = 54;

   localparam logic [7:0] CNT_SS     = 8'(cyc_min(T_SS_NS));
   localparam logic [7:0] CNT_AZ     = 8'(cyc_max(T_AZ_NS));
   localparam logic [7:0] CNT_LI     = 8'(cyc_max(T_LI_NS));
   localparam logic [7:0] CNT_MLI    = 8'(cyc_min(T_MLI_NS));
   localparam logic [7:0] CNT_RFS    = 8'(cyc_max(T_RFS_NS));
   localparam logic [7:0] CNT_RP     = 8'(cyc_min(T_RP_NS));
   localparam logic [7:0] CNT_ACK    = 8'(cyc_min(T_ACK_NS));
   localparam logic [7:0] CNT_ENV    = 8'(cyc_max(T_ENV_NS));
   localparam logic [7:0] CNT_IORDYZ = 8'(cyc_max(T_IORDYZ_NS));
   localparam logic [7:0] CNT_ZIORDY = 8'(cyc_min(T_ZIORDY_NS));
   localparam logic [7:0] CNT_DVS0   = 8'(cyc_min(T_DVS0_NS));
   localparam logic [7:0] CNT_DVS1   = 8'(cyc_min(T_DVS1_NS));
   localparam logic [7:0] CNT_DVS2   = 8'(cyc_min(T_DVS2_NS));
   localparam logic [7:0] CNT_CYC0   = 8'(cyc_min(T_CYC0_NS));
   localparam logic [7:0] CNT_CYC1   = 8'(cyc_min(T_CYC1_NS));
   localparam logic [7:0] CNT_CYC2   = 8'(cyc_min(T_CYC2_NS));

   // Values after reset and checksum constants (plain defaults).
   localparam logic [15:0] CRC_SEED    = 16'hFFFF;
   localparam logic [15:0] CRC_POLY    = 16'h1021;
   localparam logic [15:0] DD_RESET    = 16'h0000;
   localparam logic [7:0]  CNT_RESET   = 8'h00;

   typedef enum logic [3:0] {
      ST_IDLE, ST_IN_REQ, ST_IN_XFER, ST_IN_SS, ST_IN_STOPWAIT, ST_IN_TERM,
      ST_OUT_REQ, ST_OUT_ZIO, ST_OUT_STOPWAIT, ST_OUT_READY, ST_OUT_XFER
   } ubt_state_t;

endpackage

// [testbench/testbench.sv]
// Self-checking bench for the burst port with a host model on the pins.
// Assumes the core clock at 50 MHz and a free-running link clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import ubt_pkg::*;
   logic        clock, reset, link_clock, in_valid, in_end;
   logic [3:0]  pl;
   logic [1:0]  mode;
   logic [15:0] in_data, dd_o, hdd, crc_acc;
   logic        dd_oe, dmarq, drdy_strb_o, drdy_strb_oe, in_ready;
   logic        out_first, busy, crc_error, ack_n, stop, hrdy, hdd_en;
   logic        s;
   int          miscompares, n_checks;
   time         t0;

   ubt_burst ubt_burst_inst (.clock(clock), .reset(reset),
      .link_clock(link_clock), .mode(mode), .cmd_start(pl[0]),
      .cmd_done(pl[1]), .in_start(pl[2]), .in_valid(in_valid),
      .in_data(in_data), .in_end(in_end), .out_start(pl[3]),
      .dmack_n_i(ack_n), .stop_i(stop), .hrdy_strb_i(hrdy),
      .dd_i(dd_oe ? dd_o : hdd), .dd_o(dd_o), .dd_oe(dd_oe), .dmarq(dmarq),
      .drdy_strb_o(drdy_strb_o), .drdy_strb_oe(drdy_strb_oe),
      .in_ready(in_ready), .out_first(out_first), .busy(busy),
      .crc_error(crc_error));
   ubt_host_model ubt_host_model_inst (.clock(clock), .ack_n(ack_n),
      .stop(stop), .hrdy(hrdy), .hdd(hdd), .hdd_en(hdd_en));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   initial begin
      link_clock = 1'b0;
      #7.3;
      forever #62.5 link_clock = ~link_clock;
   end

   function automatic logic [15:0] crc_step(logic [15:0] c, logic [15:0] d);
      for (int b = 15; b >= 0; b--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction

   // The host's own running sum over every word the device strobes out.
   always @(posedge clock) begin
      if (in_ready === 1'b1)
         crc_acc <= crc_step(crc_acc, in_data);
   end

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Values read just after an edge are those of the edge before, so the
   // design's updates at this edge are never raced.
   task automatic wt(input int sel, input logic v);
      logic [5:0] o;
      for (int k = 0; k < 80; k++) begin
         @(posedge clock);
         o = {busy, out_first, drdy_strb_oe, drdy_strb_o, in_ready, dmarq};
         if (o[sel] === v)
            return;
      end
      chk("wait", 16'(v), 16'(o[sel]));
   endtask

   task automatic pulse(input int k);
      pl[k] <= 1'b1;
      @(posedge clock);
      pl[k] <= 1'b0;
   endtask

   // One data-in burst, ended by the host or the device; bad spoils the sum.
   task automatic in_burst(input logic hterm, input logic bad);
      int n;
      n = 2 * $urandom_range(2, 1) + 1;
      crc_acc = CRC_SEED;
      mode <= 2'($urandom_range(3, 0));
      pulse(2);
      wt(0, 1'b1);
      ubt_host_model_inst.set(1'b0, 1'b1, 1'b1, 4);
      ubt_host_model_inst.set(1'b0, 1'b0, 1'b0, 0);
      for (int k = 0; k < n; k++) begin
         in_valid <= 1'b1;
         in_data  <= 16'($urandom);
         wt(1, 1'b1);
         t0 = $time;
         chk("bus word", in_data, dd_o);
      end
      in_data <= 16'($urandom);
      if (hterm) begin
         ubt_host_model_inst.set(1'b0, 1'b0, 1'b1, 6);
         s = drdy_strb_o;
         ubt_host_model_inst.set(1'b0, 1'b0, 1'b1, 8);
         chk("halted strobe", 16'(s), 16'(drdy_strb_o));
         ubt_host_model_inst.set(1'b0, 1'b1, 1'b1, 0);
      end
      else begin
         in_valid <= 1'b0;
         in_end   <= 1'b1;
      end
      wt(0, 1'b0);
      chk("bus drive", 16'h0000, 16'(dd_oe));
      chk("gap ok", 16'h0001, 16'(($time - t0) / 20 > CNT_SS));
      ubt_host_model_inst.set(1'b0, 1'b1, 1'b1, 2);
      ubt_host_model_inst.put(bad ? ~crc_acc : crc_acc, 1'b1);
      wt(2, 1'b1);
      ubt_host_model_inst.set(1'b0, 1'b1, 1'b1, 24);
      // Keep the checksum up until the link side has latched and compared it.
      ubt_host_model_inst.set(1'b1, 1'b1, 1'b1, 24);
      wt(3, 1'b0);
      wt(5, 1'b0);
      chk("request", 16'h0000, 16'(dmarq));
      ubt_host_model_inst.put(16'h0000, 1'b0);
      in_valid <= 1'b0;
      in_end   <= 1'b0;
      $display("data-in burst done");
   endtask

   task automatic end_cmd(input logic e);
      pulse(1);
      repeat (3) @(posedge clock);
      chk("crc error", 16'(e), 16'(crc_error));
      pulse(0);
      $display("command done");
   endtask

   task tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #400000;
      miscompares++;
      tally_and_finish();
   end

   initial begin
      {pl, in_valid, in_end, in_data, crc_acc} = '0;
      reset = 1'b1;
      void'($urandom(33357));
      mode = 2'($urandom_range(2, 0));
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      in_burst(1'b0, 1'b1);
      in_burst(1'b1, 1'b0);
      end_cmd(1'b1);
      in_burst(1'b1, 1'b0);
      in_burst(1'b0, 1'b0);
      end_cmd(1'b0);
      pulse(3);
      wt(0, 1'b1);
      ubt_host_model_inst.set(1'b1, 1'b1, 1'b1, 2);
      ubt_host_model_inst.set(1'b0, 1'b1, 1'b1, 0);
      ubt_host_model_inst.set(1'b0, 1'b0, 1'b1, 0);
      wt(3, 1'b1);
      chk("ready negated", 16'h0001, 16'(drdy_strb_o));
      ubt_host_model_inst.put(16'($urandom), 1'b1);
      wt(2, 1'b0);
      ubt_host_model_inst.set(1'b0, 1'b0, 1'b1, 8);
      ubt_host_model_inst.set(1'b0, 1'b0, 1'b0, 0);
      wt(4, 1'b1);
      chk("held ready", 16'h0001, 16'({dmarq, drdy_strb_o} == 2'b10));
      ubt_host_model_inst.set(1'b0, 1'b1, 1'b1, 4);
      ubt_host_model_inst.set(1'b1, 1'b1, 1'b1, 2);
      ubt_host_model_inst.put(16'h0000, 1'b0);
      wt(5, 1'b0);
      $display("data-out start done");
      tally_and_finish();
   end
endmodule
`default_nettype wire

// [testbench/ubt_host_model.sv]
// Host end of the burst port: acknowledge, stop, ready or strobe, and bus.
// Assumes the testbench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module ubt_host_model (
   input  wire logic        clock,  // Core clock.
   output logic             ack_n,  // Acknowledge, low active.
   output logic             stop,   // Stop line.
   output logic             hrdy,   // Ready (low) or host strobe.
   output logic [15:0]      hdd,    // Host side of the data bus.
   output logic             hdd_en  // High while the host drives the bus.
);
   logic [15:0] val;
   logic        tog;

   // A released bus toggles every cycle so a stale word never passes.
   assign hdd = hdd_en ? val : {16{tog}};

   // Lines idle with acknowledge negated, stop asserted and ready negated.
   initial begin
      ack_n  = 1'b1;
      stop   = 1'b1;
      hrdy   = 1'b1;
      hdd_en = 1'b0;
      val    = 16'h0000;
      tog    = 1'b0;
   end

   always @(posedge clock) begin
      tog <= ~tog;
   end

   // Moves the lines after an edge, then holds them n cycles untouched.
   task automatic set(input logic a, input logic s, input logic h,
                      input int n);
      @(posedge clock);
      ack_n <= a;
      stop  <= s;
      hrdy  <= h;
      repeat (n) @(posedge clock);
   endtask

   // Drives or releases the bus; the checksum word stays until released.
   task automatic put(input logic [15:0] v, input logic en);
      @(posedge clock);
      val    <= v;
      hdd_en <= en;
   endtask
endmodule
`default_nettype wire
